/* src/rtc_seconds_prescaler_regs.sv */
// Behaviour
// (R1) software writes every register with full 32-bit transfers only.
// (R2) every register read or write is stretched by exactly three wait states.
// (R3) a user-mode write with the supervisor bit clear ends in an error and changes nothing.
// (R4) user-mode reads complete normally and return register contents.
// (R5) a write to a locked register completes without error but is dropped.
// (R6) while enabled the seconds count ignores writes and ticks only with both flags clear.
// (R7) seconds and prescale counts read as zero while either flag is set.
// (R8) while disabled the seconds count can be read and written.
// (R9) a seconds write while disabled clears both the overflow and invalid flags.
// (R10) software should avoid loading zero into the seconds count.
// (R11) prescale bits 31..16 are reserved, ignore writes and read zero.
// (R12) while enabled the prescale count ignores writes and counts every oscillator cycle.
// (R13) while disabled the prescale count can be read and written.
// (R14) the seconds count advances when prescale bit 14 falls from one to zero.
// (R15) status resets to 0x1, lock to 0xff, irq enables to 0x7, all others to zero.
// (R16) the seconds clock is driven out as a 1 Hz square wave.
// (R17) the prescale count wraps to zero; enable and flags both come from status.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`include "rtc_consts.svh"

module rtc_seconds_prescaler_regs (
  input  wire logic                 sys_clk,   // 10 MHz system clock
  input  wire logic                 nrst,      // synchronous reset, active low
  input  wire logic                 oscClk,    // 32.768 kHz oscillator, sampled
  input  wire logic                 psel,      // apb select
  input  wire logic                 penable,   // apb access phase
  input  wire logic                 pwrite,    // apb write
  input  wire logic [2:0]           pprot,     // apb protection, bit 0 privileged
  input  wire rtc_pkg::rtc_word_type paddr,    // apb byte address
  input  wire rtc_pkg::rtc_word_type pwdata,   // apb write data
  output logic                      pready,    // apb ready
  output logic                      pslverr,   // apb error
  output rtc_pkg::rtc_word_type     prdata,    // apb read data
  output logic                      oneHzOut,  // 1 Hz square wave
  output logic                      irq        // level interrupt
);
  import rtc_pkg::*;

  rtc_word_type     secondsCount_ff;
  rtc_prescale_type prescaleCount_ff;
  rtc_word_type     alarmValue_ff;
  rtc_word_type     compValue_ff;
  rtc_word_type     controlWord_ff;
  rtc_word_type     statusWord_ff;
  rtc_word_type     lockWord_ff;
  rtc_word_type     irqEnableWord_ff;
  rtc_event_type    evtStatus_ff;
  rtc_event_type    evtMask_ff;
  logic [1:0]       waitCnt_ff;
  logic             oscPrev_ff;
  logic             oneHz_ff;
  rtc_word_type     prdata_ff;

  rtc_index_type    regIdx;
  rtc_prescale_type nxt_prescale;
  rtc_word_type     readMux;
  rtc_event_type    evtSet;
  logic             access;
  logic             done;
  logic             mapped;
  logic             privErr;
  logic             unlocked;
  logic             wrOk;
  logic             enabled;
  logic             timeBad;
  logic             oscRise;
  logic             tick;
  logic             secStep;
  logic             secWrap;

  // address decode, shared by read and write paths
  function automatic rtc_index_type decode(input rtc_word_type a);
    if (a == `RTC_SECONDS_ADDR) begin
      decode = `RTC_IDX_SECONDS;
    end else if (a == `RTC_PRESCALE_ADDR) begin
      decode = `RTC_IDX_PRESCALE;
    end else if (a == `RTC_ALARM_ADDR) begin
      decode = `RTC_IDX_ALARM;
    end else if (a == `RTC_COMP_ADDR) begin
      decode = `RTC_IDX_COMP;
    end else if (a == `RTC_CONTROL_ADDR) begin
      decode = `RTC_IDX_CONTROL;
    end else if (a == `RTC_STATUS_ADDR) begin
      decode = `RTC_IDX_STATUS;
    end else if (a == `RTC_LOCK_ADDR) begin
      decode = `RTC_IDX_LOCK;
    end else if (a == `RTC_IRQEN_ADDR) begin
      decode = `RTC_IDX_IRQEN;
    end else if (a == `RTC_EVT_STATUS_ADDR) begin
      decode = `RTC_IDX_EVT_STATUS;
    end else if (a == `RTC_EVT_MASK_ADDR) begin
      decode = `RTC_IDX_EVT_MASK;
    end else begin
      decode = `RTC_IDX_NONE;
    end
  endfunction : decode

  assign regIdx   = decode(paddr);
  assign mapped   = (regIdx != `RTC_IDX_NONE);
  assign access   = psel & penable;
  assign done     = access & (waitCnt_ff == `RTC_WAIT_STATES);  // see (R2)
  assign privErr  = pwrite & ~pprot[0] & ~controlWord_ff[`RTC_CTL_SUPER_BIT];  // see (R3)
  // event registers sit outside the lock word
  assign unlocked = regIdx[3] | lockWord_ff[regIdx[2:0]];  // see (R5)
  assign wrOk     = done & pwrite & mapped & ~privErr & unlocked;  // see (R1) (R5)
  assign pready   = done;
  assign pslverr  = done & (privErr | ~mapped);  // see (R3) (R4)
  assign prdata   = prdata_ff;

  assign enabled  = statusWord_ff[`RTC_ST_ENABLE_BIT];  // see (R17)
  assign timeBad  = statusWord_ff[`RTC_ST_INVALID_BIT] | statusWord_ff[`RTC_ST_OVERFLOW_BIT];
  assign oscRise  = oscClk & ~oscPrev_ff;
  assign nxt_prescale = prescaleCount_ff + 16'h0001;  // see (R17)
  // falling edge of bit 14 while counting
  assign tick     = enabled & oscRise & prescaleCount_ff[`RTC_TICK_BIT]
                    & ~nxt_prescale[`RTC_TICK_BIT];  // see (R14)
  assign secStep  = tick & ~timeBad;  // see (R6)
  assign secWrap  = secStep & (secondsCount_ff == 32'hffffffff);

  assign evtSet[`RTC_EVT_SECOND_BIT]   = secStep;
  assign evtSet[`RTC_EVT_OVERFLOW_BIT] = secWrap;

  always_comb begin
    readMux = `RTC_ZERO_RESET;
    if (regIdx == `RTC_IDX_SECONDS) begin
      readMux = timeBad ? `RTC_ZERO_RESET : secondsCount_ff;  // see (R7) (R8)
    end else if (regIdx == `RTC_IDX_PRESCALE) begin
      readMux = timeBad ? `RTC_ZERO_RESET : {16'h0000, prescaleCount_ff};  // see (R7) (R11) (R13)
    end else if (regIdx == `RTC_IDX_ALARM) begin
      readMux = alarmValue_ff;
    end else if (regIdx == `RTC_IDX_COMP) begin
      readMux = compValue_ff;
    end else if (regIdx == `RTC_IDX_CONTROL) begin
      readMux = controlWord_ff;
    end else if (regIdx == `RTC_IDX_STATUS) begin
      readMux = statusWord_ff;
    end else if (regIdx == `RTC_IDX_LOCK) begin
      readMux = lockWord_ff;
    end else if (regIdx == `RTC_IDX_IRQEN) begin
      readMux = irqEnableWord_ff;
    end else if (regIdx == `RTC_IDX_EVT_STATUS) begin
      readMux = {30'h00000000, evtStatus_ff};
    end else if (regIdx == `RTC_IDX_EVT_MASK) begin
      readMux = {30'h00000000, evtMask_ff};
    end
  end

  // wait-state counter, restarts with every access phase
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      waitCnt_ff <= 2'd0;
    end else if (access && !done) begin
      waitCnt_ff <= waitCnt_ff + 2'd1;  // see (R2)
    end else begin
      waitCnt_ff <= 2'd0;
    end
  end

  // read data tracks the mux during the wait states, so it is settled at completion
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      prdata_ff <= `RTC_ZERO_RESET;
    end else if (access && !pwrite) begin
      prdata_ff <= readMux;  // see (R4)
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      oscPrev_ff <= 1'b0;
      oneHz_ff   <= 1'b0;
    end else begin
      oscPrev_ff <= oscClk;
      oneHz_ff   <= prescaleCount_ff[`RTC_TICK_BIT];  // see (R16)
    end
  end
  assign oneHzOut = oneHz_ff;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      prescaleCount_ff <= 16'h0000;  // see (R15)
    end else if (enabled) begin
      if (oscRise) begin
        prescaleCount_ff <= nxt_prescale;  // see (R12)
      end
    end else if (wrOk && regIdx == `RTC_IDX_PRESCALE) begin
      prescaleCount_ff <= pwdata[15:0];  // see (R11) (R13)
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      secondsCount_ff <= `RTC_ZERO_RESET;  // see (R15)
    end else if (!enabled && wrOk && regIdx == `RTC_IDX_SECONDS) begin
      secondsCount_ff <= pwdata;  // see (R8) (R6)
    end else if (secStep) begin
      secondsCount_ff <= secondsCount_ff + 32'h00000001;  // see (R6) (R14)
    end
  end

  // flags are read-only to software; only the enable bit is writable
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      statusWord_ff <= `RTC_STATUS_RESET;  // see (R15)
    end else begin
      if (wrOk && regIdx == `RTC_IDX_STATUS) begin
        statusWord_ff[`RTC_ST_ENABLE_BIT] <= pwdata[`RTC_ST_ENABLE_BIT];
      end
      if (!enabled && wrOk && regIdx == `RTC_IDX_SECONDS) begin
        statusWord_ff[`RTC_ST_INVALID_BIT]  <= 1'b0;  // see (R9)
        statusWord_ff[`RTC_ST_OVERFLOW_BIT] <= 1'b0;  // see (R9)
      end else if (secWrap) begin
        statusWord_ff[`RTC_ST_OVERFLOW_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      alarmValue_ff    <= `RTC_ZERO_RESET;  // see (R15)
      compValue_ff     <= `RTC_ZERO_RESET;
      controlWord_ff   <= `RTC_ZERO_RESET;
      irqEnableWord_ff <= `RTC_IRQEN_RESET;
      lockWord_ff      <= `RTC_LOCK_RESET;
    end else if (wrOk) begin
      if (regIdx == `RTC_IDX_ALARM) begin
        alarmValue_ff <= pwdata;
      end
      if (regIdx == `RTC_IDX_COMP) begin
        compValue_ff <= pwdata;
      end
      if (regIdx == `RTC_IDX_CONTROL) begin
        controlWord_ff <= pwdata;
      end
      if (regIdx == `RTC_IDX_IRQEN) begin
        irqEnableWord_ff <= pwdata;
      end
      // lock bits only ever clear; reopening needs a reset
      if (regIdx == `RTC_IDX_LOCK) begin
        lockWord_ff <= lockWord_ff & pwdata;
      end
    end
  end

  // sticky events, write one to clear, a new event wins over the clear
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      evtStatus_ff <= 2'b00;
      evtMask_ff   <= 2'b00;
    end else begin
      if (wrOk && regIdx == `RTC_IDX_EVT_STATUS) begin
        evtStatus_ff <= (evtStatus_ff & ~pwdata[1:0]) | evtSet;
      end else begin
        evtStatus_ff <= evtStatus_ff | evtSet;
      end
      if (wrOk && regIdx == `RTC_IDX_EVT_MASK) begin
        evtMask_ff <= pwdata[1:0];
      end
    end
  end

  assign irq = |(evtStatus_ff & evtMask_ff);
endmodule : rtc_seconds_prescaler_regs

/* src/rtc_consts.svh */
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// register byte addresses
`define RTC_SECONDS_ADDR     32'h4003d000
`define RTC_PRESCALE_ADDR    32'h4003d004
`define RTC_ALARM_ADDR       32'h4003d008
`define RTC_COMP_ADDR        32'h4003d00c
`define RTC_CONTROL_ADDR     32'h4003d010
`define RTC_STATUS_ADDR      32'h4003d014
`define RTC_LOCK_ADDR        32'h4003d018
`define RTC_IRQEN_ADDR       32'h4003d01c
`define RTC_EVT_STATUS_ADDR  32'h4003d020
`define RTC_EVT_MASK_ADDR    32'h4003d024

// register indices, also the lock bit that guards each of the first eight registers
`define RTC_IDX_SECONDS      4'h0
`define RTC_IDX_PRESCALE     4'h1
`define RTC_IDX_ALARM        4'h2
`define RTC_IDX_COMP         4'h3
`define RTC_IDX_CONTROL      4'h4
`define RTC_IDX_STATUS       4'h5
`define RTC_IDX_LOCK         4'h6
`define RTC_IDX_IRQEN        4'h7
`define RTC_IDX_EVT_STATUS   4'h8
`define RTC_IDX_EVT_MASK     4'h9
`define RTC_IDX_NONE         4'hf

// field positions
`define RTC_ST_INVALID_BIT   0
`define RTC_ST_OVERFLOW_BIT  1
`define RTC_ST_ENABLE_BIT    4
`define RTC_CTL_SUPER_BIT    2
`define RTC_TICK_BIT         14
`define RTC_EVT_SECOND_BIT   0
`define RTC_EVT_OVERFLOW_BIT 1

// reset values
`define RTC_ZERO_RESET       32'h00000000
`define RTC_STATUS_RESET     32'h00000001
`define RTC_LOCK_RESET       32'h000000ff
`define RTC_IRQEN_RESET      32'h00000007

// bus timing
`define RTC_WAIT_STATES      2'd3

`endif

/* src/rtc_pkg.sv */
package rtc_pkg;
  typedef logic [31:0] rtc_word_type;
  typedef logic [15:0] rtc_prescale_type;
  typedef logic [3:0]  rtc_index_type;
  typedef logic [1:0]  rtc_event_type;
endpackage : rtc_pkg

/* verification/rtc_checker.sv */
`timescale 1ns/10ps
`include "rtc_consts.svh"
module rtc_checker (
  input wire logic                  sys_clk,  // clock
  input wire logic                  nrst,     // reset
  input wire logic                  oscClk,   // osc
  input wire logic                  psel,     // sel
  input wire logic                  penable,  // access
  input wire logic                  pwrite,   // dir
  input wire logic [2:0]            pprot,    // prot
  input wire rtc_pkg::rtc_word_type paddr,    // addr
  input wire rtc_pkg::rtc_word_type pwdata,   // wdata
  input wire logic                  pready,   // ready
  input wire logic                  pslverr,  // error
  input wire rtc_pkg::rtc_word_type prdata,   // rdata
  input wire logic                  oneHzOut, // 1 Hz
  input wire logic                  irq       // irq
);
  import rtc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic inMap;
  assign inMap = paddr >= `RTC_SECONDS_ADDR && paddr <= `RTC_EVT_MASK_ADDR && paddr[1:0] == 2'b00;
  sequence access_s; psel && $rose(penable); endsequence
  sequence wait3_s; !pready [*3] ##1 pready; endsequence
  AST_WAIT: assert property (access_s |-> wait3_s)
    else $error("ready not after three waits");
  AST_RSTVAL: assert property ($rose(nrst) |->
      !pready && prdata == 32'h0 && !irq && !oneHzOut)
    else $error("outputs not clear after reset");
  AST_READYACC: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_ERRREADY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_UNMAP: assert property (pready && !inMap |->
      pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  AST_RESV: assert property (pready && !pwrite && paddr == `RTC_PRESCALE_ADDR |->
      prdata[31:16] == 16'h0)
    else $error("reserved prescale bits set");
  AST_USERREAD: assert property (pready && !pwrite && inMap |-> !pslverr)
    else $error("mapped read refused");
  AST_HZ: assert property ($changed(oneHzOut) |=> $stable(oneHzOut) [*5])
    else $error("one hz output glitched");
endmodule : rtc_checker
bind rtc_seconds_prescaler_regs rtc_checker chk (.sys_clk(sys_clk), .nrst(nrst), .oscClk(oscClk),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pprot(pprot), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .oneHzOut(oneHzOut), .irq(irq));

/* verification/rtc_apb_master.sv */
`timescale 1ns/10ps
module rtc_apb_master (
  input  wire logic                  sys_clk, // clock
  output logic                       psel,    // sel
  output logic                       penable, // access
  output logic                       pwrite,  // dir
  output logic [2:0]                 pprot,   // prot
  output rtc_pkg::rtc_word_type      paddr,   // addr
  output rtc_pkg::rtc_word_type      pwdata,  // wdata
  input  wire logic                  pready,  // ready
  input  wire logic                  pslverr, // error
  input  wire rtc_pkg::rtc_word_type prdata   // rdata
);
  import rtc_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pprot = 3'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
  end
  // whole words only: the slave has no byte strobes
  task xfer(input logic w, input logic [2:0] p, input rtc_word_type a, input rtc_word_type d,
            output rtc_word_type q, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    pprot <= p;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : rtc_apb_master

/* verification/rtc_seconds_prescaler_regs_test.sv */
`timescale 1ns/10ps
`include "rtc_consts.svh"
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, x); end end
module rtc_seconds_prescaler_regs_test;
  import rtc_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, oscClk = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, oneHzOut, irq;
  logic [2:0] pprot;
  rtc_word_type paddr, pwdata, prdata, v, seed = 32'hcee5;
  int err_count = 0, tests_run = 0, cyc = 0, pre = 0, secs = 0;
  rtc_word_type rstExp[8] = '{0, 0, 0, 0, 0, 32'h1, 32'hff, 32'h7};
  always #50 sys_clk = ~sys_clk;
  rtc_apb_master m (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pprot(pprot), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata));
  rtc_seconds_prescaler_regs DUT (.sys_clk(sys_clk), .nrst(nrst), .oscClk(oscClk),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pprot(pprot), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .oneHzOut(oneHzOut), .irq(irq));
  function rtc_word_type rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // reads go out in user mode: privilege never refuses a read
  task rd(input rtc_word_type a, input rtc_word_type x);
    rtc_word_type q;
    logic e;
    m.xfer(1'b0, 3'h0, a, 32'h0, q, e);
    `CHK(q, x)
    `CHK(e, a > `RTC_EVT_MASK_ADDR)
  endtask : rd
  task wr(input rtc_word_type a, input rtc_word_type d, input logic p, input logic x);
    rtc_word_type q;
    logic e;
    m.xfer(1'b1, {2'b00, p}, a, d, q, e);
    `CHK(e, x)
  endtask : wr
  // osc edges spaced far apart; the model tracks bit 14 falling
  task osc(input int n, input bit live);
    int nxt;
    repeat (n) begin
      repeat (4) @(posedge sys_clk);
      oscClk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      oscClk <= 1'b0;
      nxt = (pre + 1) & 32'hffff;
      if (live && pre[14] && !nxt[14]) secs++;
      pre = nxt;
    end
  endtask : osc
  task conclude();
    $display("compares %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (rstExp[i]) rd(`RTC_SECONDS_ADDR + 4 * i, rstExp[i]);
    rd(32'h4003d028, 32'h0);
    v = rnd() | 32'h1;
    wr(`RTC_SECONDS_ADDR, v, 1'b1, 1'b0);
    rd(`RTC_STATUS_ADDR, 32'h0);
    rd(`RTC_SECONDS_ADDR, v);
    wr(`RTC_PRESCALE_ADDR, v, 1'b1, 1'b0);
    rd(`RTC_PRESCALE_ADDR, {16'h0, v[15:0]});
    wr(`RTC_ALARM_ADDR, v, 1'b0, 1'b1);
    rd(`RTC_ALARM_ADDR, 32'h0);
    wr(`RTC_CONTROL_ADDR, 32'h4, 1'b1, 1'b0);
    wr(`RTC_ALARM_ADDR, v, 1'b0, 1'b0);
    wr(`RTC_LOCK_ADDR, 32'hfb, 1'b1, 1'b0);
    wr(`RTC_ALARM_ADDR, 32'h5, 1'b1, 1'b0);
    rd(`RTC_ALARM_ADDR, v);
    secs = v;
    pre = 32'h7ffc;
    wr(`RTC_PRESCALE_ADDR, pre, 1'b1, 1'b0);
    wr(`RTC_EVT_MASK_ADDR, 32'h2, 1'b1, 1'b0);
    `CHK(oneHzOut, pre[14])
    wr(`RTC_STATUS_ADDR, 32'h10, 1'b1, 1'b0);
    wr(`RTC_SECONDS_ADDR, 32'h1, 1'b1, 1'b0);
    osc(8, 1'b1);
    rd(`RTC_SECONDS_ADDR, secs);
    `CHK(oneHzOut, pre[14])
    `CHK(irq, 1'b0)
    wr(`RTC_EVT_MASK_ADDR, 32'h1, 1'b1, 1'b0);
    @(posedge sys_clk);
    `CHK(irq, 1'b1)
    wr(`RTC_EVT_STATUS_ADDR, 32'h1, 1'b1, 1'b0);
    @(posedge sys_clk);
    `CHK(irq, 1'b0)
    wr(`RTC_PRESCALE_ADDR, 32'h0, 1'b1, 1'b0);
    rd(`RTC_PRESCALE_ADDR, pre);
    wr(`RTC_STATUS_ADDR, 32'h0, 1'b1, 1'b0);
    wr(`RTC_SECONDS_ADDR, 32'hffffffff, 1'b1, 1'b0);
    pre = 32'hffff;
    wr(`RTC_PRESCALE_ADDR, pre, 1'b1, 1'b0);
    wr(`RTC_STATUS_ADDR, 32'h10, 1'b1, 1'b0);
    osc(1, 1'b1);
    rd(`RTC_STATUS_ADDR, 32'h12);
    rd(`RTC_SECONDS_ADDR, 32'h0);
    wr(`RTC_STATUS_ADDR, 32'h0, 1'b1, 1'b0);
    wr(`RTC_SECONDS_ADDR, 32'h3, 1'b1, 1'b0);
    rd(`RTC_STATUS_ADDR, 32'h0);
    rd(`RTC_PRESCALE_ADDR, pre);
    conclude();
  end
endmodule : rtc_seconds_prescaler_regs_test
